// ### rtl/hcs_defs.svh
// Constants for the host channel status flag block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef HCS_DEFS_SVH
`define HCS_DEFS_SVH

`define HCS_DATA_W      8
`define HCS_STATUS_RST  8'h00
`define HCS_OBF_BIT     0
`define HCS_IBF_BIT     1
`define HCS_USER2_BIT   2
`define HCS_CMD_BIT     3
`define HCS_USER_MASK   8'hF4
`define HCS_FIFO_DEPTH  4
`define HCS_WORD_W      11

`endif

// ### rtl/hcs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock for both sides and a synchronous active-low reset.
`timescale 1ns/1ps

module hcs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  hcs_stream_if.snk   in_s,
  hcs_stream_if.src   out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire push  = in_s.valid && in_s.ready;
  wire pop   = out_s.valid && out_s.ready;
  wire full  = (count == (AW+1)'(DEPTH));
  wire empty = (count == '0);

  // Honest flags: ready only with room, valid only with data
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rd_ptr];

  // Storage, no reset needed on the data words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // hcs_fifo

// ### rtl/hcs_pkg.sv
// Types shared by the host channel status flag block.
// Assumes hcs_defs.svh is included before this package is compiled.
`include "hcs_defs.svh"

package hcs_pkg;

  // Channel selector carried with each host write
  typedef enum logic {
    HCS_CH1,
    HCS_CH2
  } hcs_chan_e;

  // One host write as it crosses to the system clock
  typedef struct packed {
    hcs_chan_e                  chan;
    logic                       a20;
    logic                       cmd;
    logic [`HCS_DATA_W-1:0]     data;
  } hcs_wr_s;

endpackage

// ### rtl/hcs_status_flags.sv
// Status flags and data registers for host channels 1 and 2.
// Assumes host cycle strobes come from link decode logic on lclk_i, and slave
// strobes from the local processor bus on clk_i; both kinds are one-cycle pulses.
`timescale 1ns/1ps
`include "hcs_defs.svh"

// Summary of operation
// - Host write to channel-1 input sets flag
// - Slave read of channel-1 input clears flag
// - Channel-1 input-full drives slave interrupt request
// - Fast gate-A20 mode changes channel-1 flag set
// - Slave write of channel-1 output sets flag
// - Host read or slave zero clears channel-1 output
// - Slave writing one leaves output-full unchanged
// - Channel-2 bits 7-4 are slave user bits
// - Channel-2 bit 2 is slave user bit
// - Host write latches address bit 2 into bit3
// - Channel-2 bit 1 shows unread host data
// - Channel-2 input-full set by host, cleared slave
// - Channel-2 output-full set, cleared like channel 1
// - Both status registers reset to all zeros
module hcs_status_flags #(
  parameter int FIFO_DEPTH = `HCS_FIFO_DEPTH
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // Slave processor side, clk_i domain
  input  wire logic                   slv_rd_in1_i,
  input  wire logic                   slv_rd_in2_i,
  input  wire logic                   slv_wr_out1_i,
  input  wire logic                   slv_wr_out2_i,
  input  wire logic                   slv_wr_stat1_i,
  input  wire logic                   slv_wr_stat2_i,
  input  wire logic [`HCS_DATA_W-1:0] slv_wdata_i,
  input  wire logic                   fast_a20_en_i,
  output logic [`HCS_DATA_W-1:0]      ch1_input_reg_o,
  output logic [`HCS_DATA_W-1:0]      ch2_input_reg_o,
  output logic [`HCS_DATA_W-1:0]      ch1_output_reg_o,
  output logic [`HCS_DATA_W-1:0]      ch2_output_reg_o,
  output logic [`HCS_DATA_W-1:0]      channel1_status_o,
  output logic [`HCS_DATA_W-1:0]      channel2_status_o,
  output logic                        ch1_irq_o,
  output logic                        ch2_irq_o,
  // Host link side, lclk_i domain
  input  wire logic                   lclk_i,
  input  wire logic                   hst_wr_i,
  input  wire logic                   hst_rd_i,
  input  wire logic                   hst_ch2_i,
  input  wire logic                   hst_addr2_i,
  input  wire logic                   hst_a20_i,
  input  wire logic [`HCS_DATA_W-1:0] hst_wdata_i,
  output logic [`HCS_DATA_W-1:0]      hst_rdata_o,
  output logic                        hst_busy_o
);

  localparam int DW = `HCS_DATA_W;
  localparam int WW = `HCS_WORD_W;
  localparam int SW = 4 * `HCS_DATA_W;

  // ---------------- Link domain ----------------

  logic          lrst_meta;
  logic          lrstn;
  hcs_pkg::hcs_wr_s wr_word;
  logic          wr_req_t;
  logic          rd_out1_t;
  logic          rd_out2_t;
  logic          snap_ack_t;
  logic [SW-1:0] mirror;
  logic          wr_ack_lvl;
  logic          snap_chg;
  logic          wr_ack_t;
  logic          snap_t;
  logic [SW-1:0] snap;

  // System reset brought into the link clock; held two edges longer there
  always_ff @(posedge lclk_i) begin
    lrst_meta <= rstn_i;
    lrstn     <= lrst_meta;
  end

  hcs_tsync u_wr_ack_sync (
    .clk_i    (lclk_i),
    .d_i      (wr_ack_t),
    .level_o  (wr_ack_lvl),
    .change_o ()
  );

  hcs_tsync u_snap_sync (
    .clk_i    (lclk_i),
    .d_i      (snap_t),
    .level_o  (),
    .change_o (snap_chg)
  );

  // One host write may be in flight; a write while busy is not taken
  assign hst_busy_o = (wr_req_t != wr_ack_lvl);

  wire host_wr_take = hst_wr_i && !hst_busy_o;
  wire host_rd_out  = hst_rd_i && !hst_addr2_i;

  // Capture a host write; the word stays still until acknowledged
  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      wr_word  <= '0;
      wr_req_t <= 1'b0;
    end else if (host_wr_take) begin
      wr_word.chan <= hst_ch2_i ? hcs_pkg::HCS_CH2 : hcs_pkg::HCS_CH1;
      wr_word.a20  <= hst_a20_i;
      wr_word.cmd  <= hst_addr2_i;
      wr_word.data <= hst_wdata_i;
      wr_req_t     <= ~wr_req_t;
    end
  end

  // Host output-register reads travel as toggles, one per channel
  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      rd_out1_t <= 1'b0;
      rd_out2_t <= 1'b0;
    end else if (host_rd_out) begin
      rd_out1_t <= hst_ch2_i ? rd_out1_t : ~rd_out1_t;
      rd_out2_t <= hst_ch2_i ? ~rd_out2_t : rd_out2_t;
    end
  end

  // Mirror of system state, refreshed by a toggle handshake
  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      mirror     <= '0;
      snap_ack_t <= 1'b0;
    end else if (snap_chg) begin
      mirror     <= snap;
      snap_ack_t <= ~snap_ack_t;
    end
  end

  // Read data selection: address bit 2 picks status over output register
  wire [DW-1:0] mir_stat1 = mirror[4*DW-1:3*DW];
  wire [DW-1:0] mir_stat2 = mirror[3*DW-1:2*DW];
  wire [DW-1:0] mir_out1  = mirror[2*DW-1:DW];
  wire [DW-1:0] mir_out2  = mirror[DW-1:0];
  wire [DW-1:0] rd_stat   = hst_ch2_i ? mir_stat2 : mir_stat1;
  wire [DW-1:0] rd_out    = hst_ch2_i ? mir_out2 : mir_out1;
  wire [DW-1:0] rd_sel    = hst_addr2_i ? rd_stat : rd_out;

  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      hst_rdata_o <= '0;
    end else if (hst_rd_i) begin
      hst_rdata_o <= rd_sel;
    end
  end

  // ---------------- System domain ----------------

  logic          wr_pend;
  logic          wr_req_chg;
  logic          rd1_chg;
  logic          rd2_chg;
  logic          snap_ack_lvl;

  logic [DW-1:0] in1;
  logic [DW-1:0] in2;
  logic [DW-1:0] out1;
  logic [DW-1:0] out2;
  logic          in_full1;
  logic          in_full2;
  logic          out_full1;
  logic          out_full2;
  logic          cmd1;
  logic          cmd2;
  logic [DW-1:0] user1;
  logic [DW-1:0] user2;

  hcs_tsync u_wr_req_sync (
    .clk_i    (clk_i),
    .d_i      (wr_req_t),
    .level_o  (),
    .change_o (wr_req_chg)
  );

  hcs_tsync u_rd1_sync (
    .clk_i    (clk_i),
    .d_i      (rd_out1_t),
    .level_o  (),
    .change_o (rd1_chg)
  );

  hcs_tsync u_rd2_sync (
    .clk_i    (clk_i),
    .d_i      (rd_out2_t),
    .level_o  (),
    .change_o (rd2_chg)
  );

  hcs_tsync u_snap_ack_sync (
    .clk_i    (clk_i),
    .d_i      (snap_ack_t),
    .level_o  (snap_ack_lvl),
    .change_o ()
  );

  hcs_stream_if #(.W(WW)) fill_s ();
  hcs_stream_if #(.W(WW)) drain_s ();

  hcs_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .in_s   (fill_s),
    .out_s  (drain_s)
  );

  // Fill side: the held host word enters once the FIFO has room
  assign fill_s.valid = wr_pend;
  assign fill_s.data  = wr_word;

  wire fill_take = fill_s.valid && fill_s.ready;

  // Acknowledge only after the FIFO took the word, so a full FIFO stalls the host
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_pend  <= 1'b0;
      wr_ack_t <= 1'b0;
    end else if (wr_req_chg) begin
      wr_pend  <= 1'b1;
    end else if (fill_take) begin
      wr_pend  <= 1'b0;
      wr_ack_t <= ~wr_ack_t;
    end
  end

  // Drain stalls while the slave reads an input register, keeping its data still
  assign drain_s.ready = !(slv_rd_in1_i || slv_rd_in2_i);

  hcs_pkg::hcs_wr_s hw;
  assign hw = hcs_pkg::hcs_wr_s'(drain_s.data);

  wire host_wr  = drain_s.valid && drain_s.ready;
  wire hw_ch1   = host_wr && (hw.chan == hcs_pkg::HCS_CH1);
  wire hw_ch2   = host_wr && (hw.chan == hcs_pkg::HCS_CH2);
  // With fast A20 enabled, channel-1 gate-A20 writes are dropped and do not raise the flag
  wire a20_take = fast_a20_en_i && hw.a20;
  wire set_in1  = hw_ch1 && !a20_take;
  wire set_in2  = hw_ch2;

  // Slave status writes: bit 0 written as zero clears, a one does nothing
  wire clr_out1 = (slv_wr_stat1_i && !slv_wdata_i[`HCS_OBF_BIT]) || rd1_chg;
  wire clr_out2 = (slv_wr_stat2_i && !slv_wdata_i[`HCS_OBF_BIT]) || rd2_chg;

  // Next values of the full flags; a set always wins over a clear
  wire next_in_full1  = set_in1 || (in_full1 && !slv_rd_in1_i);
  wire next_in_full2  = set_in2 || (in_full2 && !slv_rd_in2_i);
  wire next_out_full1 = slv_wr_out1_i || (out_full1 && !clr_out1);
  wire next_out_full2 = slv_wr_out2_i || (out_full2 && !clr_out2);

  // Full flags; neither side can write them to one directly
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_full1  <= 1'b0;
      in_full2  <= 1'b0;
      out_full1 <= 1'b0;
      out_full2 <= 1'b0;
    end else begin
      in_full1  <= next_in_full1;
      in_full2  <= next_in_full2;
      out_full1 <= next_out_full1;
      out_full2 <= next_out_full2;
    end
  end

  // Command/data flags follow each host write that raises an input-full flag
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd1 <= 1'b0;
      cmd2 <= 1'b0;
    end else begin
      if (set_in1) begin
        cmd1 <= hw.cmd;
      end
      if (hw_ch2) begin
        cmd2 <= hw.cmd;
      end
    end
  end

  // Data registers have no defined reset value, so none is given
  always_ff @(posedge clk_i) begin
    if (set_in1) begin
      in1 <= hw.data;
    end
    if (hw_ch2) begin
      in2 <= hw.data;
    end
    if (slv_wr_out1_i) begin
      out1 <= slv_wdata_i;
    end
    if (slv_wr_out2_i) begin
      out2 <= slv_wdata_i;
    end
  end

  // User bits: free for the slave, read-only to the host
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      user1 <= `HCS_STATUS_RST;
      user2 <= `HCS_STATUS_RST;
    end else begin
      if (slv_wr_stat1_i) begin
        user1 <= slv_wdata_i & `HCS_USER_MASK;
      end
      if (slv_wr_stat2_i) begin
        user2 <= slv_wdata_i & `HCS_USER_MASK;
      end
    end
  end

  // Status byte assembly
  wire [DW-1:0] stat1 = user1
                      | (DW'(cmd1)      << `HCS_CMD_BIT)
                      | (DW'(in_full1)  << `HCS_IBF_BIT)
                      | (DW'(out_full1) << `HCS_OBF_BIT);
  wire [DW-1:0] stat2 = user2
                      | (DW'(cmd2)      << `HCS_CMD_BIT)
                      | (DW'(in_full2)  << `HCS_IBF_BIT)
                      | (DW'(out_full2) << `HCS_OBF_BIT);

  // Snapshot for the host side; taken only once the last one was acknowledged
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      snap   <= '0;
      snap_t <= 1'b0;
    end else if (snap_ack_lvl == snap_t) begin
      snap   <= {stat1, stat2, out1, out2};
      snap_t <= ~snap_t;
    end
  end

  // Slave-facing outputs; data registers straight from flops, status bytes ORed together from flop fields
  assign ch1_input_reg_o   = in1;
  assign ch2_input_reg_o   = in2;
  assign ch1_output_reg_o  = out1;
  assign ch2_output_reg_o  = out2;
  assign channel1_status_o = stat1;
  assign channel2_status_o = stat2;

  // Interrupt requests are the input-full levels themselves
  assign ch1_irq_o = in_full1;
  assign ch2_irq_o = in_full2;

endmodule // hcs_status_flags

// ### rtl/hcs_stream_if.sv
// Valid/ready stream between the block's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface hcs_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### rtl/hcs_tsync.sv
// Two-flop level synchroniser with a change pulse behind it.
// Assumes d_i is a level or toggle from another clock domain.
`timescale 1ns/1ps

module hcs_tsync (
  input  wire logic clk_i,
  input  wire logic d_i,
  output logic      level_o,
  output logic      change_o
);
  logic meta;
  logic sync;
  logic last;

  // First flop feeds only the second; edge logic looks at later stages
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    sync <= meta;
    last <= sync;
  end

  assign level_o  = sync;
  assign change_o = sync ^ last;
endmodule // hcs_tsync

// ### test/hcs_flags_sva.sv
// Port assertions for the status flag block.
// Assumes binding to hcs_status_flags; all checks sit in the clk_i domain.
`timescale 1ns/1ps
`include "hcs_defs.svh"
module hcs_flags_sva (
  input wire logic                   clk_i,
  input wire logic                   rstn_i,
  input wire logic                   slv_rd_in1_i,
  input wire logic                   slv_rd_in2_i,
  input wire logic                   slv_wr_out1_i,
  input wire logic                   slv_wr_out2_i,
  input wire logic                   slv_wr_stat1_i,
  input wire logic                   slv_wr_stat2_i,
  input wire logic [`HCS_DATA_W-1:0] slv_wdata_i,
  input wire logic [`HCS_DATA_W-1:0] ch1_output_reg_o,
  input wire logic [`HCS_DATA_W-1:0] channel1_status_o,
  input wire logic [`HCS_DATA_W-1:0] channel2_status_o,
  input wire logic                   ch1_irq_o,
  input wire logic                   ch2_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Interrupt requests mirror the input-full flags
  property p_irq1; ch1_irq_o == channel1_status_o[1]; endproperty
  a_irq1: assert property (p_irq1) else $error("ch1 irq differs from flag");
  property p_irq2; ch2_irq_o == channel2_status_o[1]; endproperty
  a_irq2: assert property (p_irq2) else $error("ch2 irq differs from flag");
  // Drain pauses on slave reads, so a read always clears
  property p_rd1; slv_rd_in1_i |=> !channel1_status_o[1]; endproperty
  a_rd1: assert property (p_rd1) else $error("ch1 input flag not cleared");
  property p_rd2; slv_rd_in2_i |=> !channel2_status_o[1]; endproperty
  a_rd2: assert property (p_rd2) else $error("ch2 input flag not cleared");
  property p_out1;
    slv_wr_out1_i |=> channel1_status_o[0] && ch1_output_reg_o == $past(slv_wdata_i);
  endproperty
  a_out1: assert property (p_out1) else $error("ch1 output write wrong");
  // A simultaneous zero write must lose to the output write
  property p_out2; slv_wr_out2_i |=> channel2_status_o[0]; endproperty
  a_out2: assert property (p_out2) else $error("ch2 output flag not set");
  property p_zero1;
    slv_wr_stat1_i && !slv_wdata_i[0] && !slv_wr_out1_i |=> !channel1_status_o[0];
  endproperty
  a_zero1: assert property (p_zero1) else $error("zero write kept flag");
  property p_one2;
    slv_wr_stat2_i && !slv_wr_out2_i && !channel2_status_o[0] |=> !channel2_status_o[0];
  endproperty
  a_one2: assert property (p_one2) else $error("status write set flag");
  property p_user2;
    slv_wr_stat2_i |=> (channel2_status_o & `HCS_USER_MASK)
      == ($past(slv_wdata_i) & `HCS_USER_MASK);
  endproperty
  a_user2: assert property (p_user2) else $error("ch2 user bits wrong");
  property p_hold2;
    !slv_wr_stat2_i |=> $stable(channel2_status_o & `HCS_USER_MASK);
  endproperty
  a_hold2: assert property (p_hold2) else $error("ch2 user bits moved");
  property p_rst;
    disable iff (1'b0) !rstn_i |=> channel1_status_o == 8'h00 && channel2_status_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset");
endmodule // hcs_flags_sva

bind hcs_status_flags hcs_flags_sva hcs_flags_sva_inst (.clk_i, .rstn_i, .slv_rd_in1_i,
  .slv_rd_in2_i, .slv_wr_out1_i, .slv_wr_out2_i, .slv_wr_stat1_i, .slv_wr_stat2_i,
  .slv_wdata_i, .ch1_output_reg_o, .channel1_status_o, .channel2_status_o, .ch1_irq_o,
  .ch2_irq_o);

// ### test/hcs_host_model.sv
// Host processor model driving the link side of the flag block.
// Assumes lclk_i runs free; requests change at the falling link edge.
`timescale 1ns/1ps
module hcs_host_model (
  input  wire logic       lclk_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic            ch2_o,
  output logic            addr2_o,
  output logic            a20_o,
  output logic [7:0]      wdata_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    ch2_o = 1'b0;
    addr2_o = 1'b0;
    a20_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Writes wait for busy low, since a write while busy is dropped
  task automatic write(input logic c2, a2, a20, input logic [7:0] d, output bit ok);
    int n;
    n = 0;
    do begin
      @(negedge lclk_i);
      n++;
    end while (busy_i !== 1'b0 && n < 400);
    ok = (n < 400);
    wr_o = 1'b1;
    ch2_o = c2;
    addr2_o = a2;
    a20_o = a20;
    wdata_o = d;
    @(negedge lclk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Released bus must not keep the old byte
  endtask

  // Read data is valid one link edge after the taking edge
  task automatic read(input logic c2, a2, output logic [7:0] d);
    @(negedge lclk_i);
    rd_o = 1'b1;
    ch2_o = c2;
    addr2_o = a2;
    @(negedge lclk_i);
    rd_o = 1'b0;
    @(negedge lclk_i);
    d = rdata_i;
  endtask
endmodule // hcs_host_model

// ### test/tb_top.sv
// Self-checking bench for the host channel status flag block.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic       clk_i, rstn_i, lclk_i, a20en, irq1, irq2, busy;
  logic       hwr, hrd, hch2, ha2, ha20, ok;
  logic [5:0] stb;
  logic [7:0] wdata, in1, in2, out1, out2, st1, st2, rdata, hwd, got;
  int         fail_count, num_checks;

  hcs_status_flags #(.FIFO_DEPTH(4)) hcs_status_flags_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .slv_rd_in1_i(stb[0]), .slv_rd_in2_i(stb[1]), .slv_wr_out1_i(stb[2]),
    .slv_wr_out2_i(stb[3]), .slv_wr_stat1_i(stb[4]), .slv_wr_stat2_i(stb[5]),
    .slv_wdata_i(wdata), .fast_a20_en_i(a20en), .ch1_input_reg_o(in1),
    .ch2_input_reg_o(in2), .ch1_output_reg_o(out1), .ch2_output_reg_o(out2),
    .channel1_status_o(st1), .channel2_status_o(st2), .ch1_irq_o(irq1), .ch2_irq_o(irq2),
    .lclk_i(lclk_i), .hst_wr_i(hwr), .hst_rd_i(hrd), .hst_ch2_i(hch2), .hst_addr2_i(ha2),
    .hst_a20_i(ha20), .hst_wdata_i(hwd), .hst_rdata_o(rdata), .hst_busy_o(busy));
  hcs_host_model hcs_host_model_inst (.lclk_i(lclk_i), .busy_i(busy), .rdata_i(rdata),
    .wr_o(hwr), .rd_o(hrd), .ch2_o(hch2), .addr2_o(ha2), .a20_o(ha20), .wdata_o(hwd));

  // Clocks with unrelated phases
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    lclk_i = 1'b0;
    #3.3;
    forever #7.5 lclk_i = ~lclk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Slave strobes last one clk_i cycle and may coincide
  task automatic slv(input logic [5:0] s, input logic [7:0] d);
    @(negedge clk_i);
    stb = s;
    wdata = d;
    @(negedge clk_i);
    stb = 6'h00;
  endtask
  task automatic hw(input logic c2, a2, a20, input logic [7:0] d);
    hcs_host_model_inst.write(c2, a2, a20, d, ok);
    if (!ok) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  // Bounded wait until status bit idx of {st2, st1} reads v
  task automatic waitfor(input int idx, input logic v);
    int n;
    logic [15:0] both;
    // Copy first: a select straight off a concatenation is not portable
    both = {st2, st1};
    for (n = 0; n < 400 && both[idx] !== v; n++) begin
      @(negedge clk_i);
      both = {st2, st1};
    end
    if (n == 400) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic settle();
    int n;
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk_i);
    if (n == 400) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Main sequence
  initial begin
    stb = 6'h00;
    wdata = 8'h00;
    a20en = 1'b0;
    rstn_i = 1'b0;
    repeat (16) @(posedge clk_i);
    chk(st1, 8'h00);
    chk(st2, 8'h00);
    @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge lclk_i);
    hw(1'b0, 1'b1, 1'b0, 8'h5A);
    settle();
    chk(in1, 8'h5A);
    chk(st1, 8'h0A);
    chk({7'h00, irq1}, 8'h01);
    slv(6'h01, 8'h00);
    chk(st1, 8'h08);
    chk({7'h00, irq1}, 8'h00);
    for (int a = 0; a < 2; a++) begin
      hw(1'b1, a[0], 1'b0, 8'h30 + 8'(a));
      settle();
      chk(in2, 8'h30 + 8'(a));
      chk(st2, {4'h0, a[0], 3'b010});
      chk({7'h00, irq2}, 8'h01);
      slv(6'h02, 8'h00);
      chk(st2, {4'h0, a[0], 3'b000});
      chk({7'h00, irq2}, 8'h00);
    end
    slv(6'h04, 8'hC3);
    chk(out1, 8'hC3);
    chk(st1, 8'h09);
    slv(6'h10, 8'hFF);
    chk(st1, 8'hFD);
    slv(6'h10, 8'hF4);
    chk(st1, 8'hFC);
    slv(6'h04, 8'h3C);
    // Host reads come from a mirror that lags the slave side by a handshake
    repeat (10) @(negedge lclk_i);
    hcs_host_model_inst.read(1'b0, 1'b0, got);
    chk(got, 8'h3C);
    waitfor(0, 1'b0);
    chk(st1, 8'hFC);
    repeat (10) @(negedge lclk_i);
    hcs_host_model_inst.read(1'b0, 1'b1, got);
    chk(got, 8'hFC);
    slv(6'h20, 8'hFF);
    chk(st2, 8'hFC);
    slv(6'h20, 8'h00);
    chk(st2, 8'h08);
    slv(6'h28, 8'h00);
    chk(st2, 8'h09);
    chk(out2, 8'h00);
    repeat (10) @(negedge lclk_i);
    hcs_host_model_inst.read(1'b1, 1'b1, got);
    chk(got, 8'h09);
    hcs_host_model_inst.read(1'b1, 1'b0, got);
    chk(got, 8'h00);
    waitfor(8, 1'b0);
    a20en = 1'b1;
    hw(1'b0, 1'b0, 1'b1, 8'hEE);
    settle();
    chk(st1, 8'hFC);
    chk(in1, 8'h5A);
    a20en = 1'b0;
    // Slave reading every cycle stalls the drain so the FIFO fills
    @(negedge clk_i);
    stb = 6'h01;
    for (int i = 0; i < 5; i++) hw(1'b1, 1'b0, 1'b0, 8'h40 + 8'(i));
    repeat (20) @(negedge lclk_i);
    chk({7'h00, busy}, 8'h01);
    chk(st2, 8'h08);
    @(negedge clk_i);
    stb = 6'h00;
    settle();
    waitfor(9, 1'b1);
    chk(in2, 8'h44);
    chk(st2, 8'h02);
    report_and_stop();
  end
endmodule // tb_top
